// File: design/audio_port_pkg.sv
// audio port section control and mute: shared constants
// assumes a 32-bit apb register bus and one 100 MHz core clock
package audio_port_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h44;
	localparam logic [7:0] ADDR_MUTE_CTRL = 8'h48;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h4C;
	localparam logic [7:0] ADDR_INT_MASK = 8'h50;
	localparam logic [7:0] ADDR_DIV_CFG = 8'h54;
	localparam logic [7:0] ADDR_FRAME_CFG = 8'h58;
	localparam logic [7:0] ADDR_RX_STATUS = 8'h5C;

	// ************************************************************
	// global control fields
	// ************************************************************
	localparam int GC_RX_BITCLK_RUN = 0;
	localparam int GC_RX_FAST_RUN = 1;
	localparam int GC_RX_SER_ACTIVE = 2;
	localparam int GC_RX_SEQ_RUN = 3;
	localparam int GC_RX_FS_RUN = 4;
	localparam int GC_TX_BITCLK_RUN = 8;
	localparam logic [31:0] GC_WRITE_MASK = 32'h0000011F;

	// ************************************************************
	// mute control fields
	// ************************************************************
	localparam int MC_DRIVE_LSB = 0;
	localparam int MC_POLARITY = 2;
	localparam int MC_IN_ENABLE = 3;
	localparam int MC_IN_STATUS = 4;
	localparam int MC_ERR_LSB = 5;
	localparam int MC_ERR_W = 8;
	localparam logic [31:0] MC_WRITE_MASK = 32'h00001FEF;

	// mute drive modes
	localparam logic [1:0] MUTE_DRIVE_OFF = 2'h0;
	localparam logic [1:0] MUTE_DRIVE_HIGH = 2'h1;
	localparam logic [1:0] MUTE_DRIVE_LOW = 2'h2;

	// interrupt events
	localparam int IRQ_W = 3;
	localparam int IRQ_MUTE = 0;
	localparam int IRQ_FRAME = 1;
	localparam int IRQ_MUTE_IN = 2;

	localparam logic [31:0] RESET_ZERO = 32'h00000000;
	localparam int DIV_W = 8;
	localparam int SLOT_W = 5;
endpackage : audio_port_pkg

// File: design/clock_divider.sv
// programmable clock-enable divider
// assumes a synchronous hold input from the control register
`timescale 1ns/1ns
module clock_divider import audio_port_pkg::*; #(
	parameter int WIDTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_run,
	input wire logic i_in_tick,
	input wire logic [WIDTH-1:0] i_ratio,
	output logic o_tick
);
	// a zero-width counter could never hold a ratio
	if (WIDTH < 1) begin : g_bad_width
		$error("divider width too small");
	end
	logic [WIDTH-1:0] count_reg;
	wire last = (count_reg == i_ratio);
	// held divider passes its input straight through
	assign o_tick = i_run ? (i_in_tick & last) : i_in_tick;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_reg <= '0;
		end else if (i_ce) begin
			if (!i_run || (i_in_tick && last)) begin
				count_reg <= '0;
			end else if (i_in_tick) begin
				count_reg <= count_reg + WIDTH'(1);
			end
		end
	end
endmodule : clock_divider

// File: design/rx_sequencer.sv
// receive frame sync generator and slot sequencer
// assumes a bit-clock tick one core cycle wide
`timescale 1ns/1ns
module rx_sequencer import audio_port_pkg::*; #(
	parameter int SW = 5
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_bit_tick,
	input wire logic i_fs_run,
	input wire logic i_seq_run,
	input wire logic [DIV_W-1:0] i_frame_len,
	input wire logic [SW-1:0] i_slots,
	output logic o_fsync,
	output logic [SW-1:0] o_slot,
	output logic o_frame_done
);
	if (SW < 1) begin : g_bad_slot_width
		$error("slot counter width too small");
	end
	logic [DIV_W-1:0] bit_reg;
	logic [SW-1:0] slot_reg;
	logic hunt_reg;
	wire fs_now = i_fs_run && i_bit_tick && (bit_reg == '0);
	assign o_fsync = fs_now;
	assign o_slot = slot_reg;
	assign o_frame_done = i_seq_run && fs_now && !hunt_reg;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bit_reg <= '0;
		end else if (i_ce) begin
			if (!i_fs_run) begin
				bit_reg <= '0;
			end else if (i_bit_tick) begin
				bit_reg <= (bit_reg == i_frame_len) ? '0 : bit_reg + DIV_W'(1);
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slot_reg <= '0;
			hunt_reg <= 1'b1;
		end else if (i_ce) begin
			if (!i_seq_run) begin
				slot_reg <= '0;
				hunt_reg <= 1'b1;
			end else if (fs_now) begin
				hunt_reg <= 1'b0;
				slot_reg <= '0;
			end else if (!hunt_reg && i_bit_tick && slot_reg != i_slots) begin
				slot_reg <= slot_reg + SW'(1);
			end
		end
	end
endmodule : rx_sequencer

// File: design/audio_port_ctrl.sv
// audio port section control, clock dividers, receive path and mute
// assumes an apb master on i_core_clk and async pins for mute input and errors
//
// Function
// - tx bit divider held, passes input undivided
// - bits 7-5 reserved, read zero
// - rx frame sync generator held while zero
// - rx sequencer held; hunts frame sync on release
// - slot counter starts at zero
// - clear then set flushes receive buffer
// - rx serializer cleared while active bit low
// - rx fast divider held while zero
// - rx bit divider held, divide-by-one
// - mute control register at 48h
// - mute register reflects live pin state
// - enabled error drives mute output
// - polarity bit selects active-low sensing
// - mute input enable gates input status into mute, not the read-back status bit or its interrupt
`timescale 1ns/1ns
module audio_port_ctrl import audio_port_pkg::*; #(
	parameter int SLOTS = 8
) (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_aux_clk_tick,
	input wire logic i_rx_data,
	input wire logic i_mute_input_pin,
	input wire logic [MC_ERR_W-1:0] i_err_events,
	output logic o_mute_output,
	output logic o_mute_output_oe,
	output logic o_rx_bitclk,
	output logic o_rx_fsync,
	output logic o_tx_bitclk,
	output logic o_irq
);
	// the slot counter is only SLOT_W bits wide
	if (SLOTS < 1 || SLOTS > (1 << SLOT_W)) begin : g_bad_slots
		$error("slot count out of range");
	end

	// ************************************************************
	// reset and pin synchronisers
	// ************************************************************
	logic rst_s1_reg, rst_n;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end

	localparam int PIN_W = MC_ERR_W + 3;
	logic [PIN_W-1:0] pin_s1_reg, pin_s2_reg;
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end else if (i_ce) begin
			pin_s1_reg <= {i_err_events, i_mute_input_pin, i_rx_data, i_aux_clk_tick};
			pin_s2_reg <= pin_s1_reg;
		end
	end
	wire aux_s = pin_s2_reg[0];
	wire rx_data_s = pin_s2_reg[1];
	wire mute_pin_s = pin_s2_reg[2];
	wire [MC_ERR_W-1:0] err_s = pin_s2_reg[PIN_W-1:3];
	logic aux_d_reg;
	wire aux_rise = aux_s & ~aux_d_reg;

	// ************************************************************
	// apb register slave
	// ************************************************************
	logic [31:0] gctl_reg, mctl_reg, div_cfg_reg, frame_cfg_reg;
	logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
	wire acc = i_psel & i_penable & i_ce;
	wire wr = acc & i_pwrite;
	wire [31:0] strb_mask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
		input logic [31:0] bmask, input logic [31:0] wmask);
		logic [31:0] m;
		m = bmask & wmask;
		merge = (old & ~m) | (wdat & m);
	endfunction : merge

	wire hit_gctl = (i_paddr == ADDR_GLOBAL_CTRL);
	wire hit_mctl = (i_paddr == ADDR_MUTE_CTRL);
	wire hit_stat = (i_paddr == ADDR_INT_STATUS);
	wire hit_mask = (i_paddr == ADDR_INT_MASK);
	wire hit_div = (i_paddr == ADDR_DIV_CFG);
	wire hit_frm = (i_paddr == ADDR_FRAME_CFG);
	wire hit_rxs = (i_paddr == ADDR_RX_STATUS);
	wire hit_any = hit_gctl | hit_mctl | hit_stat | hit_mask | hit_div | hit_frm | hit_rxs;

	// control fields
	wire tx_bitclk_div_run = gctl_reg[GC_TX_BITCLK_RUN];
	wire rx_framesync_gen_run = gctl_reg[GC_RX_FS_RUN];
	wire rx_sequencer_run = gctl_reg[GC_RX_SEQ_RUN];
	wire rx_serializer_active = gctl_reg[GC_RX_SER_ACTIVE];
	wire rx_fast_div_run = gctl_reg[GC_RX_FAST_RUN];
	wire rx_bitclk_div_run = gctl_reg[GC_RX_BITCLK_RUN];
	wire [1:0] mute_drive_mode = mctl_reg[MC_DRIVE_LSB +: 2];
	wire mute_in_polarity = mctl_reg[MC_POLARITY];
	wire mute_in_enable = mctl_reg[MC_IN_ENABLE];
	wire [MC_ERR_W-1:0] err_mute_en = mctl_reg[MC_ERR_LSB +: MC_ERR_W];

	wire mute_in_status = mute_pin_s ^ mute_in_polarity;

	wire [31:0] mctl_view = mctl_reg | ({31'h0, mute_in_status} << MC_IN_STATUS);

	logic [31:0] rx_shift_reg, rx_buf_reg;
	logic rx_full_reg;
	wire [SLOT_W-1:0] slot;

	wire [31:0] rdata_next =
		hit_gctl ? gctl_reg :
		hit_mctl ? mctl_view :
		hit_stat ? {29'h0, irq_stat_reg} :
		hit_mask ? {29'h0, irq_mask_reg} :
		hit_div ? div_cfg_reg :
		hit_frm ? frame_cfg_reg :
		hit_rxs ? {26'h0, rx_full_reg, slot} : RESET_ZERO;

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_prdata <= RESET_ZERO;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else if (i_ce) begin
			o_pready <= i_psel & ~i_penable;
			o_pslverr <= i_psel & ~i_penable & ~hit_any;
			o_prdata <= (i_psel & ~i_penable & ~i_pwrite) ? rdata_next : RESET_ZERO;
		end
	end
	wire done = acc & o_pready;
	wire wdone = done & wr;

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gctl_reg <= RESET_ZERO;
			mctl_reg <= RESET_ZERO;
			div_cfg_reg <= RESET_ZERO;
			frame_cfg_reg <= RESET_ZERO;
			irq_mask_reg <= '0;
		end else if (wdone) begin
			if (hit_gctl) gctl_reg <= merge(gctl_reg, i_pwdata, strb_mask, GC_WRITE_MASK);
			if (hit_mctl) mctl_reg <= merge(mctl_reg, i_pwdata, strb_mask, MC_WRITE_MASK);
			if (hit_div) div_cfg_reg <= merge(div_cfg_reg, i_pwdata, strb_mask, '1);
			if (hit_frm) frame_cfg_reg <= merge(frame_cfg_reg, i_pwdata, strb_mask, '1);
			if (hit_mask) irq_mask_reg <= i_pwdata[IRQ_W-1:0];
		end
	end

	// ************************************************************
	// clock dividers
	// ************************************************************
	wire fast_tick, rx_bit_tick, tx_bit_tick;
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) aux_d_reg <= 1'b0;
		else if (i_ce) aux_d_reg <= aux_s;
	end
	clock_divider #(.WIDTH(DIV_W)) u_rx_fast (.i_clk(i_core_clk), .i_rst_n(rst_n), .i_ce(i_ce),
		.i_run(rx_fast_div_run), .i_in_tick(aux_rise), .i_ratio(div_cfg_reg[7:0]), .o_tick(fast_tick));
	clock_divider #(.WIDTH(DIV_W)) u_rx_bit (.i_clk(i_core_clk), .i_rst_n(rst_n), .i_ce(i_ce),
		.i_run(rx_bitclk_div_run), .i_in_tick(fast_tick), .i_ratio(div_cfg_reg[15:8]),
		.o_tick(rx_bit_tick));
	clock_divider #(.WIDTH(DIV_W)) u_tx_bit (.i_clk(i_core_clk), .i_rst_n(rst_n), .i_ce(i_ce),
		.i_run(tx_bitclk_div_run), .i_in_tick(aux_rise), .i_ratio(div_cfg_reg[23:16]),
		.o_tick(tx_bit_tick));

	// ************************************************************
	// receive sequencing and serializer
	// ************************************************************
	wire fsync, frame_done;
	rx_sequencer #(.SW(SLOT_W)) u_seq (.i_clk(i_core_clk), .i_rst_n(rst_n), .i_ce(i_ce),
		.i_bit_tick(rx_bit_tick), .i_fs_run(rx_framesync_gen_run), .i_seq_run(rx_sequencer_run),
		.i_frame_len(frame_cfg_reg[7:0]), .i_slots(SLOT_W'(SLOTS - 1)),
		.o_fsync(fsync), .o_slot(slot), .o_frame_done(frame_done));

	// reading rx status clears the full flag, data stays in the buffer; no back-pressure to the link
	wire rbuf_read = done & ~i_pwrite & hit_rxs;
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_shift_reg <= RESET_ZERO;
			rx_buf_reg <= RESET_ZERO;
			rx_full_reg <= 1'b0;
		end else if (i_ce) begin
			if (!rx_serializer_active) begin
				rx_shift_reg <= RESET_ZERO;
				rx_buf_reg <= RESET_ZERO;
				rx_full_reg <= 1'b0;
			end else begin
				if (rx_bit_tick && rx_sequencer_run) rx_shift_reg <= {rx_shift_reg[30:0], rx_data_s};
				if (frame_done) begin
					rx_buf_reg <= rx_shift_reg;
					rx_full_reg <= 1'b1;
				end else if (rbuf_read) begin
					rx_full_reg <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// mute output and interrupts
	// ************************************************************
	// enabled errors mute
	wire mute_active = (|(err_s & err_mute_en)) | (mute_in_enable & mute_in_status);
	wire mute_level_next = (mute_drive_mode == MUTE_DRIVE_LOW) ? ~mute_active : mute_active;
	wire mute_oe_next = (mute_drive_mode == MUTE_DRIVE_HIGH) | (mute_drive_mode == MUTE_DRIVE_LOW);
	wire [IRQ_W-1:0] irq_evt = {mute_in_status, frame_done, mute_active};
	wire [IRQ_W-1:0] irq_clr = (wdone & hit_stat) ? i_pwdata[IRQ_W-1:0] : '0;

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_reg <= '0;
			o_irq <= 1'b0;
			o_mute_output <= 1'b0;
			o_mute_output_oe <= 1'b0;
			o_rx_bitclk <= 1'b0;
			o_rx_fsync <= 1'b0;
			o_tx_bitclk <= 1'b0;
		end else if (i_ce) begin
			// set wins over clear
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
			o_irq <= |(irq_stat_reg & irq_mask_reg);
			o_mute_output <= mute_level_next;
			o_mute_output_oe <= mute_oe_next;
			o_rx_bitclk <= rx_bit_tick;
			o_rx_fsync <= fsync;
			o_tx_bitclk <= tx_bit_tick;
		end
	end
endmodule : audio_port_ctrl

// File: test/audio_port_ctrl_properties.sv
// checker: apb answer, register read-back, frame sync hold, mute drive
// assumes it is bound to audio_port_ctrl and the master never issues back-to-back transfers
`timescale 1ns/1ns
module audio_port_ctrl_properties import audio_port_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_aux_clk_tick,
	input wire logic i_rx_data,
	input wire logic i_mute_input_pin,
	input wire logic [MC_ERR_W-1:0] i_err_events,
	input wire logic o_mute_output,
	input wire logic o_mute_output_oe,
	input wire logic o_rx_bitclk,
	input wire logic o_rx_fsync,
	input wire logic o_tx_bitclk,
	input wire logic o_irq
);
	// ************************************************************
	// shadow copies of the two control registers
	// ************************************************************
	logic wr_hit;
	logic [31:0] gc_reg;
	logic [31:0] mc_reg;
	assign wr_hit = i_psel && i_penable && o_pready && i_pwrite;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			gc_reg <= RESET_ZERO;
			mc_reg <= RESET_ZERO;
		end else if (wr_hit && i_paddr == ADDR_GLOBAL_CTRL) begin
			gc_reg <= i_pwdata;
		end else if (wr_hit && i_paddr == ADDR_MUTE_CTRL) begin
			mc_reg <= i_pwdata;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	// ************************************************************
	// properties
	// ************************************************************
	a_ready_after_setup: assert property (i_psel && !i_penable && i_ce |=> o_pready)
		else $error("no answer after setup");
	a_ready_one_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_slverr_reads_zero: assert property (o_pslverr |-> o_pready && o_prdata == RESET_ZERO)
		else $error("bad error answer");
	a_rdata_idle_zero: assert property (!o_pready |-> o_prdata == RESET_ZERO)
		else $error("read data outside access");
	a_gc_readback: assert property (o_pready && !i_pwrite && i_paddr == ADDR_GLOBAL_CTRL
		|-> o_prdata == (gc_reg & GC_WRITE_MASK)) else $error("control read-back wrong");
	a_mute_readback: assert property (o_pready && !i_pwrite && i_paddr == ADDR_MUTE_CTRL
		|-> (o_prdata & 32'hFFFFFFEF) == (mc_reg & MC_WRITE_MASK)) else $error("mute read-back wrong");
	a_fsync_held: assert property ((!gc_reg[GC_RX_FS_RUN]) [*3] |-> !o_rx_fsync)
		else $error("frame sync while held");
	a_mute_off_oe: assert property ((mc_reg[1:0] == MUTE_DRIVE_OFF) [*4] |-> !o_mute_output_oe)
		else $error("mute pin driven in off mode");
	a_mute_in_drive: assert property ((mc_reg[1:0] == MUTE_DRIVE_HIGH && mc_reg[MC_IN_ENABLE]
		&& (i_mute_input_pin ^ mc_reg[MC_POLARITY])) [*5] |-> o_mute_output && o_mute_output_oe)
		else $error("mute input not driving output");
	a_mute_in_ignored: assert property ((mc_reg[1:0] == MUTE_DRIVE_HIGH && !mc_reg[MC_IN_ENABLE]
		&& mc_reg[12:5] == 8'h00 && i_err_events == 8'h00) [*5] |-> !o_mute_output)
		else $error("mute active with input disabled");
endmodule : audio_port_ctrl_properties

bind audio_port_ctrl audio_port_ctrl_properties u_props (.i_core_clk, .i_arst_n, .i_ce, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_aux_clk_tick, .i_rx_data,
	.i_mute_input_pin, .i_err_events, .o_mute_output, .o_mute_output_oe, .o_rx_bitclk, .o_rx_fsync,
	.o_tx_bitclk, .o_irq);

// File: test/audio_source_model.sv
// far side: free-running master clock, serial data, mute and error lines
// assumes the bench steers the mute and error levels
`timescale 1ns/1ns
module audio_source_model (
	input wire logic i_mute_req,
	input wire logic [7:0] i_err,
	output logic o_aux_clk,
	output logic o_rx_data,
	output logic o_mute_pin,
	output logic [7:0] o_err
);
	// ************************************************************
	// 40 ns master clock, phase offset from the core clock
	// ************************************************************
	logic data_reg = 1'b0;
	initial begin
		o_aux_clk = 1'b0;
		#3;
		forever #20 o_aux_clk = ~o_aux_clk;
	end
	// data changes on the falling edge so it never races the sampler
	always @(negedge o_aux_clk) begin
		data_reg <= ~data_reg;
	end
	assign o_rx_data = data_reg;
	assign o_mute_pin = i_mute_req;
	assign o_err = i_err;
endmodule : audio_source_model

// File: test/audio_port_section_reset_and_mute_tb.sv
// bench: apb sequences for section control, dividers, frame sync and mute
// assumes audio_port_ctrl with the audio_source_model on its serial side
`timescale 1ns/1ns
module audio_port_section_reset_and_mute_tb import audio_port_pkg::*;;
	logic i_core_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h00000000, o_prdata, rd;
	logic [3:0] i_pstrb = 4'hF;
	logic o_pready, o_pslverr, sl, i_aux_clk_tick, i_rx_data, i_mute_input_pin, mreq = 1'b0;
	logic o_mute_output, o_mute_output_oe, o_rx_bitclk, o_rx_fsync, o_tx_bitclk, o_irq, counting = 1'b0;
	logic [7:0] err = 8'h00, i_err_events;
	int fails = 0, tests_run = 0, edges = 0, rxp = 0, txp = 0, fsn = 0;
	int dr[4] = '{1, 2, 8, 1};
	int dt[4] = '{1, 1, 1, 4};
	logic [31:0] gcv[4] = '{32'h00000000, 32'h00000002, 32'h00000003, 32'h00000100};
	logic [11:0] mt[8] = '{12'h092, 12'h09F, 12'h0DA, 12'h0D7, 12'h053, 12'h0E3, 12'h0C1, 12'h0F1};
	always #5 i_core_clk = ~i_core_clk;
	audio_port_ctrl uut (.i_core_clk, .i_arst_n, .i_ce(1'b1), .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_aux_clk_tick, .i_rx_data, .i_mute_input_pin,
		.i_err_events, .o_mute_output, .o_mute_output_oe, .o_rx_bitclk, .o_rx_fsync, .o_tx_bitclk, .o_irq);
	audio_source_model far (.i_mute_req(mreq), .i_err(err), .o_aux_clk(i_aux_clk_tick), .o_rx_data(i_rx_data),
		.o_mute_pin(i_mute_input_pin), .o_err(i_err_events));
	always @(posedge i_aux_clk_tick) begin
		if (counting) edges++;
	end
	always @(posedge i_core_clk) begin
		if (counting && o_rx_bitclk) rxp++;
		if (counting && o_tx_bitclk) txp++;
		if (counting && o_rx_fsync) fsn++;
	end
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic end_sim();
		if (fails == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_core_clk);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			end_sim();
		end
		rd = o_prdata;
		sl = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		check(rd & m, e);
	endtask : rchk
	task automatic window(input int n);
		edges = 0;
		rxp = 0;
		txp = 0;
		fsn = 0;
		counting <= 1'b1;
		repeat (n) @(posedge i_core_clk);
		counting <= 1'b0;
		@(posedge i_core_clk);
	endtask : window
	function automatic logic near(input int p, input int d);
		return (p * d - edges) <= 2 * d + 2 && (edges - p * d) <= 2 * d + 2;
	endfunction : near
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		repeat (16) @(posedge i_core_clk);
		i_arst_n <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		rchk(ADDR_GLOBAL_CTRL, 32'hFFFFFFFF, RESET_ZERO);
		rchk(ADDR_MUTE_CTRL, 32'hFFFFFFFF, RESET_ZERO);
		apb(1'b1, ADDR_MUTE_CTRL, 32'hFFFFFFFF);
		rchk(ADDR_MUTE_CTRL, 32'hFFFFFFFF, 32'h00001FFF);
		apb(1'b1, 8'h60, 32'hFFFFFFFF);
		check(sl, 1'b1);
		check(rd, RESET_ZERO);
		apb(1'b1, ADDR_DIV_CFG, 32'h00030301);
		apb(1'b1, ADDR_FRAME_CFG, 32'h00000003);
		// held dividers pass ticks through, running ones divide
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, ADDR_GLOBAL_CTRL, gcv[i] | 32'h000000E0);
			rchk(ADDR_GLOBAL_CTRL, 32'hFFFFFFFF, gcv[i]);
			window(400);
			check({near(rxp, dr[i]), near(txp, dt[i])}, 2'b11);
		end
		apb(1'b1, ADDR_GLOBAL_CTRL, 32'h00000102);
		rchk(ADDR_GLOBAL_CTRL, 32'hFFFFFFFF, 32'h00000102);
		apb(1'b1, ADDR_GLOBAL_CTRL, 32'h00000103);
		rchk(ADDR_GLOBAL_CTRL, 32'hFFFFFFFF, 32'h00000103);
		apb(1'b1, ADDR_GLOBAL_CTRL, 32'h0000010F);
		rchk(ADDR_GLOBAL_CTRL, 32'hFFFFFFFF, 32'h0000010F);
		rchk(ADDR_RX_STATUS, 32'h0000001F, 32'h00000000);
		window(300);
		check(fsn, 0);
		apb(1'b1, ADDR_GLOBAL_CTRL, 32'h0000011F);
		window(600);
		check(fsn >= 3, 1'b1);
		apb(1'b1, ADDR_GLOBAL_CTRL, 32'h0000010F);
		apb(1'b1, ADDR_GLOBAL_CTRL, 32'h0000010B);
		apb(1'b1, ADDR_GLOBAL_CTRL, 32'h0000010F);
		rchk(ADDR_RX_STATUS, 32'h00000020, 32'h00000000);
		apb(1'b1, ADDR_GLOBAL_CTRL, 32'h00000107);
		apb(1'b1, ADDR_GLOBAL_CTRL, 32'h0000010F);
		rchk(ADDR_RX_STATUS, 32'h0000001F, 32'h00000000);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, ADDR_MUTE_CTRL, {24'h000000, mt[i][11:4]});
			mreq <= mt[i][3];
			repeat (6) @(posedge i_core_clk);
			check({o_mute_output & o_mute_output_oe, o_mute_output_oe}, mt[i][2:1]);
			rchk(ADDR_MUTE_CTRL, 32'h00000010, {27'h0, mt[i][0], 4'h0});
		end
		apb(1'b1, ADDR_INT_MASK, 32'h00000000);
		apb(1'b1, ADDR_MUTE_CTRL, 32'h00000001);
		err <= 8'h01;
		repeat (6) @(posedge i_core_clk);
		check(o_mute_output, 1'b0);
		// stale mute events from the table are cleared first, so the next set is fresh
		apb(1'b1, ADDR_INT_STATUS, 32'h00000007);
		rchk(ADDR_INT_STATUS, 32'h00000007, 32'h00000000);
		apb(1'b1, ADDR_MUTE_CTRL, 32'h00000021);
		repeat (6) @(posedge i_core_clk);
		check({o_mute_output, o_irq}, 2'b10);
		rchk(ADDR_INT_STATUS, 32'h00000001, 32'h00000001);
		apb(1'b1, ADDR_INT_MASK, 32'h00000001);
		repeat (3) @(posedge i_core_clk);
		check(o_irq, 1'b1);
		err <= 8'h00;
		apb(1'b1, ADDR_MUTE_CTRL, 32'h00000000);
		repeat (6) @(posedge i_core_clk);
		apb(1'b1, ADDR_INT_STATUS, 32'h00000001);
		repeat (3) @(posedge i_core_clk);
		check(o_irq, 1'b0);
		rchk(ADDR_INT_STATUS, 32'h00000001, 32'h00000000);
		end_sim();
	end
endmodule : audio_port_section_reset_and_mute_tb
